// ---- rtl/scs_clock_ctrl.sv ----
//
// Contract
// - reset selects undivided internal oscillator
// - select 000..011 divide oscillator by 1/2/4/8
// - 100 external pin, 101 rtc, others reserved
// - select bits 7:3 read zero, writes ignored
// - override bit forces external clock source
// - hold zero without pin control gates oscillator output only
// - power enable zero unpowers the oscillator
// - pin control with hold zero: rise stops, fall restarts
// - reserved bit 3 reads zero, write zero
// - writing 0x00 shuts oscillator down
// - fixed eight-bit revision code, read only
//
module scs_clock_ctrl #(
    parameter logic [7:0] REVISION_CODE = 8'h5a // arbitrary value
) (
    input  wire logic                 core_clk,        // 125 MHz clock
    input  wire logic                 nrst,            // async reset, active low
    input  wire logic                 ce,              // clock enable
    input  wire scs_pkg::scs_reg_req_t reg_req,        // register request
    output logic [7:0]                reg_rdata,       // read data, one cycle after rd
    input  wire logic                 ext_clk,         // external cmos clock pin
    input  wire logic                 rtc_clk,         // rtc oscillator level
    input  wire logic                 ext_override,    // external_clock_override
    output logic                      sys_clk,         // selected system clock
    output logic [2:0]                sys_src,         // source now driving sys_clk
    output logic                      osc_powered,     // oscillator has power
    output logic                      osc_clk_on       // oscillator output ungated
);
    import scs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [2:0]    source_select;  // source_select_field
    scs_osc_ctl_t  osc_ctl;        // oscillator_control_reg fields
    logic          ext_prev;       // last sampled ext_clk
    logic          pin_stopped;    // oscillator stopped by the pin
    scs_sw_state_t sw_state;       // switch sequencer state
    logic [DIV_TAPS-1:0] taps;     // divider outputs
    logic          next_clk_on;    // next oscillator output enable
    logic [2:0]    want_src;       // source requested now

    // level of a source code; reserved codes read low
    // source decode
    function automatic logic src_level(input logic [2:0] code,
                                       input logic [DIV_TAPS-1:0] t,
                                       input logic ext, input logic rtc);
        unique case (code)
            SRC_DIV1: src_level = t[0];
            SRC_DIV2: src_level = t[1];
            SRC_DIV4: src_level = t[2];
            SRC_DIV8: src_level = t[3];
            SRC_EXT:  src_level = ext;
            SRC_RTC:  src_level = rtc;
            default:  src_level = 1'b0;
        endcase
    endfunction : src_level

    function automatic logic is_write(input scs_reg_req_t r, input logic [7:0] a);
        is_write = r.wr && (r.addr == a);
    endfunction : is_write

    function automatic logic is_read(input scs_reg_req_t r, input logic [7:0] a);
        is_read = r.rd && (r.addr == a);
    endfunction : is_read

    // source select register; reserved codes are not taken
    // reset selects div1
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            source_select <= RST_SOURCE_SELECT[SEL_MSB:SEL_LSB];
        end else if (ce && is_write(reg_req, ADDR_SOURCE_SELECT)) begin
            if (reg_req.wdata[SEL_MSB:SEL_LSB] <= SRC_RTC) begin
                source_select <= reg_req.wdata[SEL_MSB:SEL_LSB];
            end
        end
    end

    // oscillator control register; bit 3 and up are not stored
    // reserved bit dropped
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            osc_ctl <= RST_OSC_CONTROL[OSC_HOLD_BIT:OSC_PIN_BIT];
        end else if (ce && is_write(reg_req, ADDR_OSC_CONTROL)) begin
            osc_ctl.hold <= reg_req.wdata[OSC_HOLD_BIT];
            osc_ctl.pwr  <= reg_req.wdata[OSC_PWR_BIT];
            osc_ctl.pin  <= reg_req.wdata[OSC_PIN_BIT];
        end
    end

    // read path; registered, unmapped reads zero
    // upper select bits zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= READ_UNMAPPED;
        end else if (ce && reg_req.rd) begin
            if (is_read(reg_req, ADDR_SOURCE_SELECT)) begin
                reg_rdata <= {5'h00, source_select};
            end else if (is_read(reg_req, ADDR_OSC_CONTROL)) begin
                reg_rdata <= {4'h0, 1'b0, osc_ctl.hold, osc_ctl.pwr, osc_ctl.pin};
            end else if (is_read(reg_req, ADDR_REVISION)) begin
                reg_rdata <= REVISION_CODE;
            end else begin
                reg_rdata <= READ_UNMAPPED;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // oscillator enable

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_prev    <= 1'b0;
            pin_stopped <= 1'b0;
        end else if (ce) begin
            ext_prev <= ext_clk;
            if (!osc_ctl.pin || osc_ctl.hold) begin
                pin_stopped <= 1'b0;
            end else if (ext_clk && !ext_prev) begin
                pin_stopped <= 1'b1;
            end else if (!ext_clk && ext_prev) begin
                pin_stopped <= 1'b0;
            end
        end
    end

    always_comb begin
        next_clk_on = osc_ctl.pwr &&
                      (osc_ctl.hold || (osc_ctl.pin && !pin_stopped));
    end

    // power enable, all zeros shut down
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            osc_powered <= RST_OSC_CONTROL[OSC_PWR_BIT];
            osc_clk_on  <= RST_OSC_CONTROL[OSC_HOLD_BIT];
        end else if (ce) begin
            osc_powered <= osc_ctl.pwr;
            osc_clk_on  <= next_clk_on;
        end
    end

    // oscillator and its divider chain
    scs_osc_div #(
        .TAPS (DIV_TAPS)
    ) u_osc_div (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ce       (ce),
        .run      (osc_clk_on),
        .taps     (taps)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // source switching

    always_comb begin
        want_src = ext_override ? SRC_EXT : source_select;
    end

    // drain high phase, wait for low of new source, then switch
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sw_state <= SW_RUN;
            sys_src  <= SRC_DIV1;
            sys_clk  <= 1'b0;
        end else if (ce) begin
            unique case (sw_state)
                SW_RUN: begin
                    sys_clk <= src_level(sys_src, taps, ext_clk, rtc_clk);
                    if (want_src != sys_src) begin
                        sw_state <= SW_DRAIN;
                    end
                end
                SW_DRAIN: begin
                    sys_clk <= src_level(sys_src, taps, ext_clk, rtc_clk);
                    if (!src_level(sys_src, taps, ext_clk, rtc_clk)) begin
                        sw_state <= SW_ALIGN;
                    end
                end
                SW_ALIGN: begin
                    sys_clk <= 1'b0;
                    if (!src_level(want_src, taps, ext_clk, rtc_clk)) begin
                        sys_src  <= want_src;
                        sw_state <= SW_RUN;
                    end
                end
                default: begin
                    sw_state <= SW_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic first_cyc; // high for the first cycle after reset release
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            first_cyc <= 1'b1;
        end else begin
            first_cyc <= 1'b0;
        end
    end

    property p_reset_src;
        first_cyc |-> (sys_src == SRC_DIV1) && (source_select == SRC_DIV1) && osc_clk_on;
    endproperty
    a_reset_src: assert property (p_reset_src) else $error("reset source not div1");

    property p_div_follow;
        (ce && sw_state == SW_RUN && want_src == sys_src && sys_src == SRC_DIV2)
            |=> sys_clk == $past(taps[1]);
    endproperty
    a_div_follow: assert property (p_div_follow) else $error("div2 not followed");

    property p_rsv_ignored;
        (ce && reg_req.wr && reg_req.addr == ADDR_SOURCE_SELECT
            && reg_req.wdata[SEL_MSB:SEL_LSB] > SRC_RTC)
            |=> $stable(source_select);
    endproperty
    a_rsv_ignored: assert property (p_rsv_ignored) else $error("reserved code taken");

    property p_sel_upper;
        (ce && reg_req.rd && reg_req.addr == ADDR_SOURCE_SELECT)
            |=> reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] == $past(source_select);
    endproperty
    a_sel_upper: assert property (p_sel_upper) else $error("select readback wrong");

    property p_override;
        (ce && $past(ce) && ext_override && $past(ext_override)
            && sw_state == SW_RUN && $past(sw_state) == SW_RUN) |-> sys_src == SRC_EXT;
    endproperty
    a_override: assert property (p_override) else $error("override not honoured");

    property p_gate;
        (ce && !osc_ctl.hold && !osc_ctl.pin) |=> !osc_clk_on;
    endproperty
    a_gate: assert property (p_gate) else $error("oscillator not gated");

    property p_power;
        (ce && !osc_ctl.pwr) |=> !osc_powered && !osc_clk_on;
    endproperty
    a_power: assert property (p_power) else $error("oscillator powered");

    property p_pin_stop;
        (ce && osc_ctl.pin && !osc_ctl.hold && ext_clk && !ext_prev) |=> ##1 !osc_clk_on;
    endproperty
    a_pin_stop: assert property (p_pin_stop) else $error("pin rise did not stop");

    property p_rsv_read;
        (ce && reg_req.rd && reg_req.addr == ADDR_OSC_CONTROL) |=> reg_rdata[7:3] == 5'h00;
    endproperty
    a_rsv_read: assert property (p_rsv_read) else $error("osc reserved bits set");

    property p_rev;
        (ce && reg_req.rd && reg_req.addr == ADDR_REVISION) |=> reg_rdata == REVISION_CODE;
    endproperty
    a_rev: assert property (p_rev) else $error("revision code wrong");

    property p_switch;
        $changed(sys_src) |-> $past(sw_state) == SW_ALIGN && !$past(sys_clk) && !sys_clk;
    endproperty
    a_switch: assert property (p_switch) else $error("unsafe source switch");

    property p_hold_on;
        (ce && osc_ctl.hold && osc_ctl.pwr) |=> osc_clk_on;
    endproperty
    a_hold_on: assert property (p_hold_on) else $error("hold did not keep output");

    property p_pwr_on;
        (ce && osc_ctl.pwr) |=> osc_powered;
    endproperty
    a_pwr_on: assert property (p_pwr_on) else $error("power not applied");

    property p_pin_go;
        (ce && !reg_req.wr && osc_ctl.pin && !osc_ctl.hold && osc_ctl.pwr
            && !ext_clk && ext_prev) ##1 ce |=> osc_clk_on;
    endproperty
    a_pin_go: assert property (p_pin_go) else $error("pin fall did not restart");

    property p_shutdown;
        (ce && reg_req.wr && reg_req.addr == ADDR_OSC_CONTROL && reg_req.wdata == 8'h00)
            ##1 ce |=> !osc_powered && !osc_clk_on;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("zero write did not shut down");

    property p_align_low;
        (sw_state == SW_ALIGN) |-> !sys_clk;
    endproperty
    a_align_low: assert property (p_align_low) else $error("clock not low while aligning");

endmodule : scs_clock_ctrl

// ---- rtl/scs_pkg.sv ----
package scs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map, indirect register interface
    localparam logic [7:0] ADDR_SOURCE_SELECT = 8'h32; // source_select_register
    localparam logic [7:0] ADDR_OSC_CONTROL   = 8'h33; // oscillator_control_reg
    localparam logic [7:0] ADDR_REVISION      = 8'h34; // revision_code

    // values after reset
    localparam logic [7:0] RST_SOURCE_SELECT  = 8'h00;
    localparam logic [7:0] RST_OSC_CONTROL    = 8'h06;
    localparam logic [7:0] READ_UNMAPPED      = 8'h00;

    // field positions
    localparam int SEL_LSB      = 0;
    localparam int SEL_MSB      = 2;
    localparam int OSC_PIN_BIT  = 0; // osc_pin_control
    localparam int OSC_PWR_BIT  = 1; // osc_power_enable
    localparam int OSC_HOLD_BIT = 2; // osc_internal_hold
    localparam int OSC_RSV_BIT  = 3; // reserved, reads zero

    // source_select_field encodings
    localparam logic [2:0] SRC_DIV1 = 3'h0;
    localparam logic [2:0] SRC_DIV2 = 3'h1;
    localparam logic [2:0] SRC_DIV4 = 3'h2;
    localparam logic [2:0] SRC_DIV8 = 3'h3;
    localparam logic [2:0] SRC_EXT  = 3'h4;
    localparam logic [2:0] SRC_RTC  = 3'h5;

    // width of the internal divider chain (taps /1 /2 /4 /8)
    localparam int DIV_TAPS = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic       wr;    // one-cycle write strobe
        logic       rd;    // one-cycle read strobe
        logic [7:0] addr;  // register address
        logic [7:0] wdata; // write data
    } scs_reg_req_t;

    typedef struct packed {
        logic hold; // osc_internal_hold
        logic pwr;  // osc_power_enable
        logic pin;  // osc_pin_control
    } scs_osc_ctl_t;

    // clock switch sequencer
    typedef enum logic [2:0] {
        SW_RUN   = 3'b001,
        SW_DRAIN = 3'b010,
        SW_ALIGN = 3'b100
    } scs_sw_state_t;

endpackage : scs_pkg

// ---- rtl/scs_osc_div.sv ----
// internal oscillator model with its divide-by-1/2/4/8 chain
module scs_osc_div #(
    parameter int TAPS = scs_pkg::DIV_TAPS
) (
    input  wire logic            core_clk, // module clock
    input  wire logic            nrst,     // async reset, active low
    input  wire logic            ce,       // clock enable, freezes state
    input  wire logic            run,      // oscillator clock output enabled
    output logic [TAPS-1:0]      taps      // bit n = oscillator divided by 2**n
);
    import scs_pkg::*;

    // counter advanced while run and ce are high; bit 0 toggles each such cycle and stands for the oscillator
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            taps <= '0;
        end else if (ce && run) begin
            taps <= taps + TAPS'(1);
        end
    end

endmodule : scs_osc_div

// ---- tb/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import scs_pkg::*;

    localparam logic [7:0] REV_CODE = 8'h5a; // arbitrary value

    logic         core_clk;
    logic         nrst;
    logic         ce;
    scs_reg_req_t reg_req;
    logic [7:0]   reg_rdata;
    logic         ext_clk = 1'b0;
    logic         rtc_clk = 1'b0;
    logic         ext_override;
    logic         sys_clk;
    logic [2:0]   sys_src;
    logic         osc_powered;
    logic         osc_clk_on;
    logic         ext_run;
    logic         ext_lvl;
    logic [1:0]   ext_cnt = 2'h0;
    logic [2:0]   rtc_cnt = 3'h0;
    int           err_total = 0;
    int           checks = 0;

    scs_clock_ctrl #(
        .REVISION_CODE (REV_CODE)
    ) scs_clock_ctrl_i (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .ce           (ce),
        .reg_req      (reg_req),
        .reg_rdata    (reg_rdata),
        .ext_clk      (ext_clk),
        .rtc_clk      (rtc_clk),
        .ext_override (ext_override),
        .sys_clk      (sys_clk),
        .sys_src      (sys_src),
        .osc_powered  (osc_powered),
        .osc_clk_on   (osc_clk_on)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock, external pin and rtc level
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // pin toggles every third cycle when running, else follows ext_lvl
    always @(posedge core_clk) begin
        ext_cnt <= (ext_cnt == 2'h2) ? 2'h0 : ext_cnt + 2'h1;
        if (ext_run) begin
            if (ext_cnt == 2'h2) ext_clk <= ~ext_clk;
        end else begin
            ext_clk <= ext_lvl;
        end
        rtc_cnt <= (rtc_cnt == 3'h4) ? 3'h0 : rtc_cnt + 3'h1;
        if (rtc_cnt == 3'h4) rtc_clk <= ~rtc_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic summarize;
        if (err_total == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        reg_req <= '0;
    endtask : reg_write

    // read data stands from the edge that took the strobe; taken one edge later
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        reg_req <= '0;
        @(posedge core_clk);
        chk(reg_rdata, exp);
    endtask : reg_read

    task automatic wait_src(input logic [2:0] code);
        bit found;
        found = 1'b0;
        for (int i = 0; i < 300 && !found; i++) begin
            @(posedge core_clk);
            found = (sys_src === code);
        end
        chk({5'h00, sys_src}, {5'h00, code});
        if (!found) summarize();
    endtask : wait_src

    task automatic osc_expect(input logic pwr, input logic on);
        repeat (4) @(posedge core_clk);
        chk({6'h00, osc_powered, osc_clk_on}, {6'h00, pwr, on});
    endtask : osc_expect

    // length in cycles of the next whole high phase of sys_clk
    task automatic clk_half(input int exp);
        int n;
        n = 0;
        for (int i = 0; i < 40 && sys_clk !== 1'b0; i++) @(posedge core_clk);
        for (int i = 0; i < 40 && sys_clk !== 1'b1; i++) @(posedge core_clk);
        for (int i = 0; i < 40 && sys_clk === 1'b1; i++) begin
            @(posedge core_clk);
            n++;
        end
        chk(8'(n), 8'(exp));
        if (n == 0 || n == 40) summarize();
    endtask : clk_half

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        reg_req = '0;
        ext_override = 1'b0;
        ext_run = 1'b1;
        ext_lvl = 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        chk({5'h00, sys_src}, {5'h00, SRC_DIV1});
        reg_read(ADDR_SOURCE_SELECT, RST_SOURCE_SELECT);
        reg_read(ADDR_OSC_CONTROL, RST_OSC_CONTROL);
        reg_read(ADDR_REVISION, REV_CODE);
        reg_write(ADDR_REVISION, 8'h33);
        reg_read(ADDR_REVISION, REV_CODE);
        reg_read(8'h35, READ_UNMAPPED);
        for (int c = 0; c < 6; c++) begin
            reg_write(ADDR_SOURCE_SELECT, 8'(c));
            reg_read(ADDR_SOURCE_SELECT, 8'(c));
            wait_src(3'(c));
            clk_half((c < 4) ? (1 << c) : ((c == 4) ? 3 : 5));
        end
        reg_write(ADDR_SOURCE_SELECT, 8'h06);
        reg_write(ADDR_SOURCE_SELECT, 8'h07);
        reg_read(ADDR_SOURCE_SELECT, 8'h05);
        reg_write(ADDR_SOURCE_SELECT, 8'hfc);
        reg_read(ADDR_SOURCE_SELECT, 8'h04);
        wait_src(SRC_EXT);
        // read with clock enable low is not taken
        ce <= 1'b0;
        reg_read(ADDR_REVISION, 8'h04);
        ce <= 1'b1;
        // override wins over the select field
        reg_write(ADDR_SOURCE_SELECT, 8'h01);
        wait_src(SRC_DIV2);
        ext_override <= 1'b1;
        wait_src(SRC_EXT);
        ext_override <= 1'b0;
        wait_src(SRC_DIV2);
        reg_write(ADDR_SOURCE_SELECT, 8'h04);
        wait_src(SRC_EXT);
        reg_write(ADDR_OSC_CONTROL, 8'h02);
        osc_expect(1'b1, 1'b0);
        reg_write(ADDR_OSC_CONTROL, 8'hf6);
        reg_read(ADDR_OSC_CONTROL, 8'h06);
        osc_expect(1'b1, 1'b1);
        reg_write(ADDR_OSC_CONTROL, 8'h07);
        reg_write(ADDR_OSC_CONTROL, 8'h03);
        ext_run <= 1'b0;
        ext_lvl <= 1'b0;
        osc_expect(1'b1, 1'b1);
        ext_lvl <= 1'b1;
        osc_expect(1'b1, 1'b0);
        ext_lvl <= 1'b0;
        osc_expect(1'b1, 1'b1);
        // all zeros shuts the oscillator down
        reg_write(ADDR_OSC_CONTROL, 8'h00);
        osc_expect(1'b0, 1'b0);
        reg_read(ADDR_OSC_CONTROL, 8'h00);
        ext_run <= 1'b1;
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        chk({5'h00, sys_src}, {5'h00, SRC_DIV1});
        reg_read(ADDR_SOURCE_SELECT, RST_SOURCE_SELECT);
        reg_read(ADDR_OSC_CONTROL, RST_OSC_CONTROL);
        osc_expect(1'b1, 1'b1);
        summarize();
    end
endmodule : tb
